// [common/age_if.sv]
interface age_if;
  import mac_table_pkg::*;
  logic [AGE_W-1:0] age_s; // age interval in seconds
  logic aging_off; // stops aging sweeps
  logic sweep; // one-cycle sweep request
  modport timer (input age_s, input aging_off, output sweep);
  modport table_side (output age_s, output aging_off, input sweep);
endinterface

// [common/mac_table_pkg.sv]
package mac_table_pkg;
  // table geometry
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 3;
  localparam int VID_W = 12;
  localparam int MAC_W = 48;
  localparam int KEY_W = VID_W + MAC_W;
  localparam int TABLE_DEPTH = 8192;
  localparam int STATIC_MAX = 64;
  localparam int SCNT_W = 7;
  // aging in seconds
  localparam int AGE_W = 24;
  localparam int AGE_DEFAULT_S = 300;
  localparam int AGE_MIN_S = 10;
  localparam int AGE_MAX_S = 10000000;
  localparam logic [1:0] AGE_LIMIT = 2'h2;
  // one second in core cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AGE = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_TAKEN = 8'h0c;
  localparam logic [7:0] OFF_KVID = 8'h10;
  localparam logic [7:0] OFF_KMAC_LO = 8'h14;
  localparam logic [7:0] OFF_KMAC_HI = 8'h18;
  localparam logic [7:0] OFF_KPORTS = 8'h1c;
  localparam logic [7:0] OFF_CMD = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // learning modes
  localparam logic [1:0] LM_AUTO = 2'h0;
  localparam logic [1:0] LM_DISABLE = 2'h1;
  localparam logic [1:0] LM_SECURE = 2'h2;
  // command codes
  localparam logic [2:0] CMD_ADD = 3'h1;
  localparam logic [2:0] CMD_DEL = 3'h2;
  localparam logic [2:0] CMD_GET = 3'h3;
  localparam logic [2:0] CMD_NEXT = 3'h4;
  // engine operations and states
  typedef enum logic [2:0] {OP_FRAME, OP_ADD, OP_DEL, OP_GET, OP_NEXT, OP_SWEEP} op_t;
  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_DONE} state_t;
  // one table entry
  typedef struct packed {
    logic valid;
    logic stat;
    logic [1:0] age;
    logic [VID_W-1:0] vid;
    logic [MAC_W-1:0] mac;
    logic [NUM_PORTS-1:0] ports;
  } entry_t;
endpackage

// [src/age_timer.sv]
module age_timer
  import mac_table_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // aging control
  age_if.timer age
);
  logic [31:0] cyc_q, cyc_d; // cycles within a second
  logic [AGE_W-1:0] sec_q, sec_d; // seconds within half interval
  logic sweep_q, sweep_d; // sweep pulse
  logic [AGE_W-1:0] half_s; // half interval, last second index

  assign half_s = (age.age_s >> 1) - {{(AGE_W-1){1'b0}}, 1'b1};
  assign age.sweep = sweep_q;

  // sweep twice per interval, entries die on the third sweep
  always_comb
  begin
    cyc_d = cyc_q;
    sec_d = sec_q;
    sweep_d = 1'b0;
    if (age.aging_off)
    begin
      // aging held off, counters parked
      cyc_d = '0;
      sec_d = '0;
    end
    else if (cyc_q == 32'(SEC_CYC - 1))
    begin
      cyc_d = '0;
      if (sec_q >= half_s)
      begin
        sec_d = '0;
        sweep_d = 1'b1;
      end
      else
        sec_d = sec_q + {{(AGE_W-1){1'b0}}, 1'b1};
    end
    else
      cyc_d = cyc_q + 32'h1;
  end

  // register counters
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cyc_q <= '0;
      sec_q <= '0;
      sweep_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_d;
      sec_q <= sec_d;
      sweep_q <= sweep_d;
    end
  end
endmodule

// [src/mac_learning_table.sv]
// Implementation choices: the AHB-Lite slave port and the register offsets.
module mac_learning_table
  import mac_table_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH,
  parameter int STATIC_CAP = STATIC_MAX,
  parameter int SEC_CYC = SEC_CYCLES
)(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // frame lookup request
  input wire logic FRM_VALID,
  output logic FRM_READY,
  input wire logic [PORT_W-1:0] FRM_PORT,
  input wire logic [VID_W-1:0] FRM_VID,
  input wire logic [MAC_W-1:0] FRM_SRC,
  input wire logic [MAC_W-1:0] FRM_DST,
  // forwarding answer
  output logic RES_VALID,
  output logic RES_DROP,
  output logic [NUM_PORTS-1:0] RES_PORTS,
  // learning mode takeover
  input wire logic [NUM_PORTS-1:0] LEARN_TAKEN,
  input wire logic [2*NUM_PORTS-1:0] LEARN_TAKEN_MODE
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [NUM_PORTS-1:0] ONE_PORT = {{(NUM_PORTS-1){1'b0}}, 1'b1};

  // table storage, one entry per index
  entry_t mem [DEPTH];
  entry_t cur; // entry under the scan index
  logic wr_en; // table write strobe
  logic [IW-1:0] wr_idx; // table write index
  entry_t wr_e; // table write data
  // engine state
  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [IW-1:0] idx_q, idx_d; // scan index
  logic [KEY_W-1:0] skey_q, skey_d; // source or management key
  logic [KEY_W-1:0] dkey_q, dkey_d; // destination key
  logic [PORT_W-1:0] inport_q, inport_d; // ingress port
  logic sa_hit_q, sa_hit_d, sa_stat_q, sa_stat_d;
  logic [IW-1:0] sa_idx_q, sa_idx_d;
  logic da_hit_q, da_hit_d;
  logic [NUM_PORTS-1:0] da_ports_q, da_ports_d;
  logic free_hit_q, free_hit_d;
  logic [IW-1:0] free_idx_q, free_idx_d;
  logic best_hit_q, best_hit_d; // readout candidate found
  entry_t best_q, best_d; // smallest key past start, or at it for a get
  // software-visible state
  logic aging_off_q, aging_off_d;
  logic [AGE_W-1:0] age_q, age_d;
  logic [2*NUM_PORTS-1:0] mode_q, mode_d; // two bits per port
  logic [VID_W-1:0] kvid_q, kvid_d;
  logic [MAC_W-1:0] kmac_q, kmac_d;
  logic [NUM_PORTS-1:0] kports_q, kports_d;
  logic cmd_pend_q, cmd_pend_d;
  op_t cmd_op_q, cmd_op_d;
  logic sweep_pend_q, sweep_pend_d;
  logic eot_q, eot_d, rstat_q, rstat_d, fail_q, fail_d;
  logic [SCNT_W-1:0] scnt_q, scnt_d; // static entry count
  // frame answer
  logic rdy_q, rdy_d, res_valid_q, res_valid_d, res_drop_q, res_drop_d;
  logic [NUM_PORTS-1:0] res_ports_q, res_ports_d;
  // bus phases
  logic wpend_q, wpend_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  // helpers
  logic [2*NUM_PORTS-1:0] eff_mode; // mode after takeover
  logic [2*NUM_PORTS-1:0] taken_mask; // taken flag widened to both mode bits
  logic busy; // management op outstanding
  logic sel; // address phase accepted
  logic [1:0] fmode; // mode of the ingress port
  logic drop; // secure-mode drop decision
  logic [NUM_PORTS-1:0] inbit; // ingress port mask
  logic [KEY_W-1:0] ck; // key of current entry
  age_if age_bus();

  // ordering key of an entry
  function automatic logic [KEY_W-1:0] key_of(input entry_t e);
    return {e.vid, e.mac};
  endfunction

  // mode field of one port
  function automatic logic [1:0] mode_of(input logic [2*NUM_PORTS-1:0] m,
                                         input logic [PORT_W-1:0] p);
    return m[2*p +: 2];
  endfunction

  // takeover function drives the mode of its ports
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_mode
    assign eff_mode[2*p +: 2] = LEARN_TAKEN[p] ? LEARN_TAKEN_MODE[2*p +: 2] : mode_q[2*p +: 2];
    assign taken_mask[2*p +: 2] = {2{LEARN_TAKEN[p]}};
  end

  // aging timer
  age_timer #(.SEC_CYC(SEC_CYC)) u_age (.clk(CORE_CLK), .rst(SRST), .age(age_bus.timer));
  assign age_bus.age_s = age_q;
  assign age_bus.aging_off = aging_off_q;

  assign cur = mem[idx_q];
  assign ck = key_of(cur);
  assign sel = HSEL && HTRANS[1] && HREADY;
  assign busy = cmd_pend_q || (state_q != S_IDLE && op_q != OP_FRAME && op_q != OP_SWEEP);
  assign fmode = mode_of(eff_mode, inport_q);
  assign drop = (fmode == LM_SECURE) && !(sa_hit_q && sa_stat_q);
  assign inbit = ONE_PORT << inport_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;
  assign FRM_READY = rdy_q;
  assign RES_VALID = res_valid_q;
  assign RES_DROP = res_drop_q;
  assign RES_PORTS = res_ports_q;

  // next state of bus, registers and lookup engine
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    {idx_d, skey_d, dkey_d, inport_d} = {idx_q, skey_q, dkey_q, inport_q};
    {sa_hit_d, sa_stat_d, sa_idx_d, da_hit_d, da_ports_d} =
      {sa_hit_q, sa_stat_q, sa_idx_q, da_hit_q, da_ports_q};
    {free_hit_d, free_idx_d, best_hit_d, best_d} = {free_hit_q, free_idx_q, best_hit_q, best_q};
    {aging_off_d, age_d, mode_d} = {aging_off_q, age_q, mode_q};
    {kvid_d, kmac_d, kports_d} = {kvid_q, kmac_q, kports_q};
    cmd_pend_d = cmd_pend_q;
    cmd_op_d = cmd_op_q;
    sweep_pend_d = sweep_pend_q;
    {eot_d, rstat_d, fail_d, scnt_d} = {eot_q, rstat_q, fail_q, scnt_q};
    {res_drop_d, res_ports_d} = {res_drop_q, res_ports_q};
    res_valid_d = 1'b0;
    wr_en = 1'b0;
    wr_idx = idx_q;
    wr_e = cur;
    wpend_d = sel && HWRITE;
    waddr_d = HADDR[7:0];
    // bus write data phase
    if (wpend_q)
    begin
      if (waddr_q == OFF_CTRL)
        aging_off_d = HWDATA[0];
      else if (waddr_q == OFF_AGE)
      begin
        // out-of-range interval is dropped
        if (HWDATA >= 32'(AGE_MIN_S) && HWDATA <= 32'(AGE_MAX_S))
          age_d = HWDATA[AGE_W-1:0];
      end
      else if (waddr_q == OFF_MODE)
      begin
        for (int p = 0; p < NUM_PORTS; p++)
          if (!LEARN_TAKEN[p])
            mode_d[2*p +: 2] = HWDATA[2*p +: 2];
      end
      else if (busy)
        ; // key and command held while a management op is pending or running
      else if (waddr_q == OFF_KVID)
        kvid_d = HWDATA[VID_W-1:0];
      else if (waddr_q == OFF_KMAC_LO)
        kmac_d[31:0] = HWDATA;
      else if (waddr_q == OFF_KMAC_HI)
        kmac_d[MAC_W-1:32] = HWDATA[MAC_W-33:0];
      else if (waddr_q == OFF_KPORTS)
        kports_d = HWDATA[NUM_PORTS-1:0];
      else if (waddr_q == OFF_CMD)
      begin
        cmd_pend_d = 1'b1;
        if (HWDATA[2:0] == CMD_ADD)
          cmd_op_d = OP_ADD;
        else if (HWDATA[2:0] == CMD_DEL)
          cmd_op_d = OP_DEL;
        else if (HWDATA[2:0] == CMD_GET)
          cmd_op_d = OP_GET;
        else if (HWDATA[2:0] == CMD_NEXT)
          cmd_op_d = OP_NEXT;
        else
          cmd_pend_d = 1'b0; // unknown code ignored
      end
    end
    case (state_q)
      S_IDLE:
      begin
        // sweep first, then software, then frames
        if (sweep_pend_q)
        begin
          op_d = OP_SWEEP;
          sweep_pend_d = 1'b0;
          state_d = S_SCAN;
        end
        else if (cmd_pend_q)
        begin
          op_d = cmd_op_q;
          cmd_pend_d = 1'b0;
          skey_d = {kvid_q, kmac_q};
          dkey_d = {kvid_q, kmac_q};
          fail_d = 1'b0;
          state_d = S_SCAN;
        end
        else if (FRM_VALID && rdy_q)
        begin
          op_d = OP_FRAME;
          skey_d = {FRM_VID, FRM_SRC};
          dkey_d = {FRM_VID, FRM_DST};
          inport_d = FRM_PORT;
          state_d = S_SCAN;
        end
        idx_d = '0;
        {sa_hit_d, da_hit_d, free_hit_d, best_hit_d} = 4'h0;
      end
      S_SCAN:
      begin
        // one entry compared per cycle
        if (cur.valid && ck == skey_q)
        begin
          sa_hit_d = 1'b1;
          sa_idx_d = idx_q;
          sa_stat_d = cur.stat;
        end
        if (cur.valid && ck == dkey_q)
        begin
          da_hit_d = 1'b1;
          da_ports_d = cur.ports;
        end
        if (!cur.valid && !free_hit_q)
        begin
          free_hit_d = 1'b1;
          free_idx_d = idx_q;
        end
        // smallest key past the start point, or at it for a get
        if (cur.valid && (ck > skey_q || (ck == skey_q && op_q == OP_GET))
            && (!best_hit_q || ck < key_of(best_q)))
        begin
          best_hit_d = 1'b1;
          best_d = cur;
        end
        // age only learned entries
        if (op_q == OP_SWEEP && cur.valid && !cur.stat)
        begin
          wr_en = 1'b1;
          if (cur.age == AGE_LIMIT)
            wr_e.valid = 1'b0;
          else
            wr_e.age = cur.age + 2'h1;
        end
        if (idx_q == IW'(DEPTH - 1))
          state_d = S_DONE;
        else
          idx_d = idx_q + {{(IW-1){1'b0}}, 1'b1};
      end
      S_DONE:
      begin
        state_d = S_IDLE;
        wr_e.valid = 1'b1;
        wr_e.stat = 1'b0;
        wr_e.age = 2'h0;
        wr_e.vid = skey_q[KEY_W-1 -: VID_W];
        wr_e.mac = skey_q[MAC_W-1:0];
        wr_e.ports = inbit;
        case (op_q)
          OP_FRAME:
          begin
            res_valid_d = 1'b1;
            res_drop_d = drop;
            res_ports_d = drop ? '0 : ((da_hit_q ? da_ports_q : '1) & ~inbit);
            if (fmode == LM_AUTO)
            begin
              // learn or refresh, static entries untouched
              if (sa_hit_q)
              begin
                wr_en = !sa_stat_q;
                wr_idx = sa_idx_q;
              end
              else
              begin
                wr_en = free_hit_q;
                wr_idx = free_idx_q;
              end
            end
          end
          OP_ADD:
          begin
            wr_e.stat = 1'b1;
            wr_e.ports = kports_q;
            wr_idx = sa_hit_q ? sa_idx_q : free_idx_q;
            if (sa_hit_q && sa_stat_q)
              wr_en = 1'b1;
            else if (32'(scnt_q) < STATIC_CAP && (sa_hit_q || free_hit_q))
            begin
              wr_en = 1'b1;
              scnt_d = scnt_q + {{(SCNT_W-1){1'b0}}, 1'b1};
            end
            else
              fail_d = 1'b1;
          end
          OP_DEL:
          begin
            wr_idx = sa_idx_q;
            wr_e.valid = 1'b0;
            if (sa_hit_q && sa_stat_q)
            begin
              wr_en = 1'b1;
              scnt_d = scnt_q - {{(SCNT_W-1){1'b0}}, 1'b1};
            end
            else
              fail_d = 1'b1;
          end
          OP_GET, OP_NEXT:
          begin
            eot_d = !best_hit_q;
            if (best_hit_q)
            begin
              kvid_d = best_q.vid;
              kmac_d = best_q.mac;
              kports_d = best_q.ports;
              rstat_d = best_q.stat;
            end
          end
          default:
            ;
        endcase
      end
      default:
        state_d = S_IDLE;
    endcase
    // a sweep tick in the launch cycle is kept
    if (age_bus.sweep)
      sweep_pend_d = 1'b1;
    rdy_d = (state_d == S_IDLE) && !sweep_pend_d && !cmd_pend_d;
    // read data from next values, so write-then-read sees new data
    hrdata_d = 32'h0;
    if (sel && !HWRITE)
    begin
      if (HADDR[7:0] == OFF_CTRL)
        hrdata_d[0] = aging_off_d;
      else if (HADDR[7:0] == OFF_AGE)
        hrdata_d[AGE_W-1:0] = age_d;
      else if (HADDR[7:0] == OFF_MODE)
        hrdata_d[2*NUM_PORTS-1:0] = mode_d;
      else if (HADDR[7:0] == OFF_TAKEN)
        hrdata_d[NUM_PORTS-1:0] = LEARN_TAKEN;
      else if (HADDR[7:0] == OFF_KVID)
        hrdata_d[VID_W-1:0] = kvid_d;
      else if (HADDR[7:0] == OFF_KMAC_LO)
        hrdata_d = kmac_d[31:0];
      else if (HADDR[7:0] == OFF_KMAC_HI)
        hrdata_d[MAC_W-33:0] = kmac_d[MAC_W-1:32];
      else if (HADDR[7:0] == OFF_KPORTS)
        hrdata_d[NUM_PORTS-1:0] = kports_d;
      else if (HADDR[7:0] == OFF_STATUS)
        hrdata_d = {17'h0, scnt_d, 4'h0, fail_d, rstat_d, eot_d, busy};
    end
  end

  // register everything but the table
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      state_q <= S_IDLE;
      op_q <= OP_FRAME;
      {idx_q, skey_q, dkey_q, inport_q} <= '0;
      {sa_hit_q, sa_stat_q, sa_idx_q, da_hit_q, da_ports_q} <= '0;
      {free_hit_q, free_idx_q, best_hit_q, best_q} <= '0;
      aging_off_q <= 1'b0;
      age_q <= AGE_W'(AGE_DEFAULT_S);
      mode_q <= '0;
      {kvid_q, kmac_q, kports_q} <= '0;
      cmd_pend_q <= 1'b0;
      cmd_op_q <= OP_GET;
      sweep_pend_q <= 1'b0;
      {eot_q, rstat_q, fail_q, scnt_q} <= '0;
      {rdy_q, res_valid_q, res_drop_q, res_ports_q} <= '0;
      {wpend_q, waddr_q, hrdata_q} <= '0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      {idx_q, skey_q, dkey_q, inport_q} <= {idx_d, skey_d, dkey_d, inport_d};
      {sa_hit_q, sa_stat_q, sa_idx_q, da_hit_q, da_ports_q} <=
        {sa_hit_d, sa_stat_d, sa_idx_d, da_hit_d, da_ports_d};
      {free_hit_q, free_idx_q, best_hit_q, best_q} <= {free_hit_d, free_idx_d, best_hit_d, best_d};
      {aging_off_q, age_q, mode_q} <= {aging_off_d, age_d, mode_d};
      {kvid_q, kmac_q, kports_q} <= {kvid_d, kmac_d, kports_d};
      cmd_pend_q <= cmd_pend_d;
      cmd_op_q <= cmd_op_d;
      sweep_pend_q <= sweep_pend_d;
      {eot_q, rstat_q, fail_q, scnt_q} <= {eot_d, rstat_d, fail_d, scnt_d};
      {rdy_q, res_valid_q, res_drop_q, res_ports_q} <= {rdy_d, res_valid_d, res_drop_d, res_ports_d};
      {wpend_q, waddr_q, hrdata_q} <= {wpend_d, waddr_d, hrdata_d};
    end
  end

  // table write port, reset empties every slot
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0; // whole entry, so a fresh slot never reads as static
    end
    else if (wr_en)
      mem[wr_idx] <= wr_e;
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  AST_FWD_KNOWN: assert property (
    state_q == S_DONE && op_q == OP_FRAME && da_hit_q && !drop
    |=> RES_VALID && RES_PORTS == ($past(da_ports_q) & ~$past(inbit)))
    else $error("known destination not forwarded to its ports");
  AST_SECURE_DROP: assert property (
    state_q == S_DONE && op_q == OP_FRAME && fmode == LM_SECURE && !(sa_hit_q && sa_stat_q)
    |=> RES_VALID && RES_DROP && RES_PORTS == '0)
    else $error("secure port passed a non-static source");
  AST_DISABLE_NOLEARN: assert property (
    state_q == S_DONE && op_q == OP_FRAME && fmode != LM_AUTO |-> !wr_en)
    else $error("non-auto port learned an entry");
  AST_STATIC_SAFE: assert property (
    wr_en && (op_q == OP_FRAME || op_q == OP_SWEEP) |-> !mem[wr_idx].stat)
    else $error("learning or aging touched a static entry");
  AST_AGE_RANGE: assert property (
    wpend_q && waddr_q == OFF_AGE && (HWDATA < 32'(AGE_MIN_S) || HWDATA > 32'(AGE_MAX_S))
    |=> age_q == $past(age_q))
    else $error("out-of-range age interval accepted");
  AST_TAKEN_MODE: assert property (
    wpend_q && waddr_q == OFF_MODE
    |=> ((mode_q ^ $past(mode_q)) & $past(taken_mask)) == '0
    && (mode_q & ~$past(taken_mask)) == ($past(HWDATA[2*NUM_PORTS-1:0]) & ~$past(taken_mask)))
    else $error("mode write reached a taken-over port");
  AST_STATIC_CAP: assert property (
    32'(scnt_q) <= STATIC_CAP)
    else $error("static entry count above capacity");
  AST_END_TABLE: assert property (
    state_q == S_DONE && (op_q == OP_GET || op_q == OP_NEXT) && !best_hit_q |=> eot_q)
    else $error("end of table not reported");
  AST_AGING_OFF: assert property (
    aging_off_q [*2] |-> !age_bus.sweep)
    else $error("sweep while aging is off");
  COV_FORWARD: cover property (RES_VALID && !RES_DROP);
  COV_LEARN: cover property (state_q == S_DONE && op_q == OP_FRAME && wr_en);
  COV_STATIC_ADD: cover property (state_q == S_DONE && op_q == OP_ADD && wr_en);
  COV_EOT: cover property (state_q == S_DONE && op_q == OP_NEXT && !best_hit_q);
endmodule

// [test/frame_src.sv]
module frame_src
  import mac_table_pkg::*;
(
  // clock
  input wire logic clk,
  // frame request
  output logic valid,
  input wire logic ready,
  output logic [PORT_W-1:0] port,
  output logic [VID_W-1:0] vid,
  output logic [MAC_W-1:0] src,
  output logic [MAC_W-1:0] dst,
  // answer strobe
  input wire logic res_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    valid = 1'b0;
    {port, vid, src, dst} = '0;
  end
  // one frame: hold until taken, then wait for its answer
  task automatic send(input logic [PORT_W-1:0] p, input logic [VID_W-1:0] v,
    input logic [MAC_W-1:0] s, input logic [MAC_W-1:0] d, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    valid <= 1'b1;
    {port, vid, src, dst} <= {p, v, s, d};
    @(posedge clk);
    while (ready !== 1'b1 && n < 99)
    begin
      @(posedge clk);
      n++;
    end
    // released lines show the inverse, not the old frame
    valid <= 1'b0;
    {port, vid, src, dst} <= ~{p, v, s, d};
    n = 0;
    while (!ok && n < 99)
    begin
      @(posedge clk);
      n++;
      ok = (res_valid === 1'b1);
    end
  endtask
endmodule

// [test/testbench.sv]
module testbench
  import mac_table_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, hready, hresp, fv, fr, rv, rdrop;
  logic [1:0] htrans;
  logic [2:0] hsize, fp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [11:0] fvid;
  logic [47:0] fs, fd;
  logic [7:0] rports, taken;
  logic [15:0] tmode;
  int n_mismatch, compares;
  bit ok;
  localparam logic [47:0] MA = 48'h0a00, MB = 48'h0b00, MX = 48'hffff;
  mac_learning_table #(.DEPTH(16), .STATIC_CAP(4), .SEC_CYC(20)) i_dut (
    .CORE_CLK(clk), .SRST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .FRM_VALID(fv), .FRM_READY(fr),
    .FRM_PORT(fp), .FRM_VID(fvid), .FRM_SRC(fs), .FRM_DST(fd), .RES_VALID(rv),
    .RES_DROP(rdrop), .RES_PORTS(rports), .LEARN_TAKEN(taken), .LEARN_TAKEN_MODE(tmode));
  frame_src i_src (.clk(clk), .valid(fv), .ready(fr), .port(fp), .vid(fvid), .src(fs),
    .dst(fd), .res_valid(rv));
  // clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single ahb-lite word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // command, then poll busy under a bound
  task automatic cmd(input logic [2:0] c);
    bus(1'b1, OFF_CMD, {29'h0, c});
    for (int i = 0; i < 20; i++)
    begin
      bus(1'b0, OFF_STATUS, 32'h0);
      if (r[0] === 1'b0) break;
    end
    // busy still set after the poll bound counts as a mismatch
    chk({31'h0, r[0]}, 32'h0);
  endtask
  task automatic frm(input logic [2:0] p, input logic [47:0] s, input logic [47:0] d,
    input logic dr, input logic [7:0] exp);
    i_src.send(p, 12'h1, s, d, ok);
    chk({ok, rdrop, rports}, {1'b1, dr, exp});
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, taken, tmode} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFF_AGE, 32'd300);
    rdc(OFF_STATUS, 32'h0);
    $display("reset values done");
    bus(1'b1, OFF_AGE, 32'd9);
    rdc(OFF_AGE, 32'd300);
    bus(1'b1, OFF_AGE, 32'd10000001);
    rdc(OFF_AGE, 32'd300);
    bus(1'b1, OFF_AGE, 32'd10);
    rdc(OFF_AGE, 32'd10);
    bus(1'b1, OFF_AGE, 32'd10000000);
    rdc(OFF_AGE, 32'd10000000);
    $display("age range done");
    bus(1'b1, OFF_KVID, 32'h1);
    bus(1'b1, OFF_KMAC_LO, MA[31:0]);
    bus(1'b1, OFF_KMAC_HI, 32'h0);
    bus(1'b1, OFF_KPORTS, 32'h0c);
    cmd(CMD_ADD);
    rdc(OFF_STATUS, 32'h100);
    frm(3'h0, MA, MA, 1'b0, 8'h0c);
    frm(3'h2, MB, MX, 1'b0, 8'hfb);
    frm(3'h0, MA, MB, 1'b0, 8'h04);
    $display("static and learn done");
    bus(1'b1, OFF_MODE, 32'h240);
    frm(3'h3, 48'h0c00, MX, 1'b0, 8'hf7);
    frm(3'h0, MA, 48'h0c00, 1'b0, 8'hfe);
    frm(3'h4, MA, MX, 1'b0, 8'hef);
    frm(3'h4, 48'h0d00, MX, 1'b1, 8'h00);
    taken <= 8'h20;
    tmode <= 16'h400;
    bus(1'b1, OFF_MODE, 32'h640);
    rdc(OFF_MODE, 32'h240);
    rdc(OFF_TAKEN, 32'h20);
    frm(3'h5, 48'h0f00, MX, 1'b0, 8'hdf);
    frm(3'h0, MA, 48'h0f00, 1'b0, 8'hfe);
    $display("modes done");
    bus(1'b1, OFF_KMAC_LO, 32'h0);
    cmd(CMD_GET);
    rdc(OFF_KMAC_LO, MA[31:0]);
    rdc(OFF_STATUS, 32'h104);
    cmd(CMD_NEXT);
    rdc(OFF_KMAC_LO, MB[31:0]);
    rdc(OFF_STATUS, 32'h100);
    cmd(CMD_NEXT);
    rdc(OFF_STATUS, 32'h102);
    $display("readout done");
    bus(1'b1, OFF_AGE, 32'd10);
    bus(1'b1, OFF_CTRL, 32'h1);
    frm(3'h6, 48'h0e00, MX, 1'b0, 8'hbf);
    repeat (400) @(posedge clk);
    frm(3'h0, MA, 48'h0e00, 1'b0, 8'h40);
    bus(1'b1, OFF_CTRL, 32'h0);
    repeat (400) @(posedge clk);
    frm(3'h0, MA, MB, 1'b0, 8'hfe);
    frm(3'h0, MA, 48'h0e00, 1'b0, 8'hfe);
    frm(3'h0, MA, MA, 1'b0, 8'h0c);
    bus(1'b1, OFF_KMAC_LO, MA[31:0]);
    cmd(CMD_DEL);
    rdc(OFF_STATUS, 32'h2);
    frm(3'h0, MA, MA, 1'b0, 8'hfe);
    $display("aging done");
    summarize();
  end
endmodule
